//--- logic/mtcd_pkg.sv
// package: constants, field layout and types for the task control word
package mtcd_pkg;

   // register offset and reset value
   localparam logic [11:0] CTRL_WORD_OFFSET = 12'h214;
   localparam logic [31:0] CTRL_WORD_RESET  = 32'h0000_0000;

   // operating mode that enables writes, commands and triggers
   localparam logic [3:0]  OPMODE_POSITION  = 4'h2;

   // field positions inside the control word
   localparam int TYPE_LSB    = 0;
   localparam int CHAIN_BIT   = 4;
   localparam int NEXT_LSB    = 5;
   localparam int SHAPE_LSB   = 10;
   localparam int OVR_BIT     = 12;
   localparam int LOCK_BIT    = 13;
   localparam int NOSTILL_BIT = 14;
   localparam int RSVD_BIT    = 15;

   // target computation encodings
   localparam logic [3:0] TYPE_ABSOLUTE = 4'h0;
   localparam logic [3:0] TYPE_REL_CMD  = 4'h1;
   localparam logic [3:0] TYPE_REL_PREV = 4'h3;
   localparam logic [3:0] TYPE_REL_FB   = 4'h7;

   // next-task start encodings
   localparam logic [4:0] NEXT_AFTER_STOP  = 5'h00;
   localparam logic [4:0] NEXT_AFTER_DELAY = 5'h01;
   localparam logic [4:0] NEXT_ON_THE_FLY  = 5'h18;

   // profile shape encodings
   localparam logic [1:0] SHAPE_TRAPEZOID = 2'h0;
   localparam logic [1:0] SHAPE_TABLE_1TO1 = 2'h1;
   localparam logic [1:0] SHAPE_TABLE_STD = 2'h3;

   // task store size
   localparam int TASK_COUNT = 128;
   localparam int TASK_AW    = 7;

   // delay timebase: following delay counts in milliseconds
   localparam int CLK_PERIOD_NS  = 8;
   localparam int DELAY_UNIT_NS  = 1000000;
   localparam int MS_CYCLES      = DELAY_UNIT_NS / CLK_PERIOD_NS;

   // control word seen field by field
   typedef struct packed {
      logic [15:0] upper;
      logic        reserved15;
      logic        noStandstill;
      logic        lockTrigger;
      logic        overrideEn;
      logic [1:0]  shape;
      logic [4:0]  nextStart;
      logic        chain;
      logic [3:0]  taskType;
   } mtcd_ctrl_t;

endpackage

//--- logic/mtcd_task_mem.sv
// task store: one control word per motion task, registered read
`timescale 1ns/100ps
`default_nettype none
module mtcd_task_mem #(
   parameter int DEPTH = 128,
   parameter int AW    = 7,
   parameter int WIDTH = 32
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // write side
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   // read side
   input  wire logic             rdEn,
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] memArray [DEPTH];

   // array has no reset; an unwritten task reads as whatever is stored
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         memArray[wrAddr] <= wrData;
      end
   end

   // read data from a register so the decode path starts clean
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdData <= '0;
      end else if (rdEn) begin
         rdData <= memArray[rdAddr];
      end
   end

endmodule
`default_nettype wire

//--- logic/mtcd_decoder.sv
// motion task control word staging, store, decode and sequencing
//
// Operation
// - act only in position mode two, except register reads
// - written word is staging until commit
// - commit stores staging; load restores it
// - type 0000: task position is absolute target
// - type 0001: commanded position plus task position
// - type 0011: previous target plus task position
// - type 0111: feedback position plus task position
// - bit 4 enables running next task
// - next start 00000: start after stop
// - next start 00001: stop, delay, start
// - next start 11000: fly into next task
// - shape 00: trapezoidal profile
// - shape 01: table one-to-one, no cruise
// - shape 11: table halves with cruise
// - table shapes use task table number
// - shape 11 also allows on-the-fly chaining
// - bit 12 override for trapezoidal tasks only
// - bit 13 locks out triggers while running
// - bit 14 forbids start from standstill
`timescale 1ns/100ps
`default_nettype none
module mtcd_decoder
   import mtcd_pkg::*;
#(
   parameter int POS_W      = 32,
   parameter int NUM_TASKS  = TASK_COUNT,
   parameter int MS_CYC     = MS_CYCLES
) (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   // mode selection
   input  wire logic [3:0]              opMode,
   // register port
   input  wire logic                    regWrEn,
   input  wire logic                    regRdEn,
   input  wire logic [11:0]             regAddr,
   input  wire logic [31:0]             regWrData,
   output logic      [31:0]             regRdData,
   output logic                         regRdValid,
   // task commands
   input  wire logic                    commitTaskCommand,
   input  wire logic                    loadTaskCommand,
   input  wire logic [TASK_AW-1:0]      cmdTaskNum,
   output logic                         cmdDone,
   output logic                         cmdError,
   // task trigger
   input  wire logic                    triggerReq,
   input  wire logic [TASK_AW-1:0]      triggerTaskNum,
   output logic                         triggerAccepted,
   output logic                         triggerRejected,
   // per-task parameters of the fetched task
   input  wire logic signed [POS_W-1:0] taskPositionValue,
   input  wire logic [7:0]              profileTableNumber,
   input  wire logic [15:0]             followingDelayTime,
   input  wire logic [TASK_AW-1:0]      nextTaskNum,
   // positions from the loop
   input  wire logic signed [POS_W-1:0] commandedPosition,
   input  wire logic signed [POS_W-1:0] feedbackPosition,
   // profile generator handshake
   input  wire logic                    motionDone,
   output logic                         taskStart,
   output logic                         taskRunning,
   output logic signed [POS_W-1:0]      targetPosition,
   output logic [1:0]                   profileShape,
   output logic                         tableProfile,
   output logic [7:0]                   tableSelect,
   output logic                         overrideActive,
   output logic                         flyToNext,
   output logic [TASK_AW-1:0]           activeTaskNum
);

   // sequencer states, gray along idle-fetch-decode-run
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_FETCH  = 3'b001,
      ST_DECODE = 3'b011,
      ST_RUN    = 3'b010,
      ST_DELAY  = 3'b110
   } mtcd_state_t;

   mtcd_state_t           state_reg;
   mtcd_state_t           state_next;
   logic [31:0]           staging_reg;
   mtcd_ctrl_t            stagingF;
   mtcd_ctrl_t            fetchedF;
   mtcd_ctrl_t            activeF_reg;
   logic [31:0]           memRdData;
   logic                  memRdEn;
   logic [TASK_AW-1:0]    memRdAddr;
   logic                  memWrEn;
   logic [TASK_AW-1:0]    fetchTask_reg;
   logic                  fetchChained_reg;
   logic                  loadPend_reg;
   logic                  modeOk;
   logic                  stagingValid;
   logic                  wasRunning_reg;
   logic                  startOk;
   logic                  trigTake;
   logic                  chainGo;
   logic signed [POS_W-1:0] prevTarget_reg;
   logic signed [POS_W-1:0] targetCalc;
   logic [16:0]           msCnt_reg;
   logic [15:0]           delayCnt_reg;
   logic                  delayDone;

   assign modeOk   = (opMode == OPMODE_POSITION);
   assign stagingF = mtcd_ctrl_t'(staging_reg);
   assign fetchedF = mtcd_ctrl_t'(memRdData);

   // reserved encodings and combinations fail the commit check
   always_comb begin
      stagingValid = 1'b1;
      if (!(stagingF.taskType inside {TYPE_ABSOLUTE, TYPE_REL_CMD,
                                      TYPE_REL_PREV, TYPE_REL_FB})) begin
         stagingValid = 1'b0;
      end
      if (!(stagingF.nextStart inside {NEXT_AFTER_STOP, NEXT_AFTER_DELAY,
                                       NEXT_ON_THE_FLY})) begin
         stagingValid = 1'b0;
      end
      if (stagingF.shape == 2'h2 || stagingF.reserved15) begin
         stagingValid = 1'b0;
      end
      // the one-to-one table cannot hand over on the fly
      if (stagingF.nextStart == NEXT_ON_THE_FLY &&
          stagingF.shape == SHAPE_TABLE_1TO1) begin
         stagingValid = 1'b0;
      end
   end

   // staging register: written from the port, refilled by load
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         staging_reg <= CTRL_WORD_RESET;
      end else if (loadPend_reg) begin
         staging_reg <= memRdData;
      end else if (regWrEn && modeOk && regAddr == CTRL_WORD_OFFSET) begin
         staging_reg <= regWrData;
      end
   end

   // register reads; unmapped offsets read zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         regRdData  <= '0;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn && regAddr == CTRL_WORD_OFFSET) begin
            regRdData <= staging_reg;
         end else begin
            regRdData <= '0;
         end
      end
   end

   // commit writes the store only with a valid word in position mode
   assign memWrEn = commitTaskCommand && modeOk && stagingValid;

   // fetch has the read port; a load that collides is refused
   always_comb begin
      memRdEn   = 1'b0;
      memRdAddr = cmdTaskNum;
      if (state_reg == ST_FETCH) begin
         memRdEn   = 1'b1;
         memRdAddr = fetchTask_reg;
      end else if (loadTaskCommand && modeOk) begin
         memRdEn   = 1'b1;
      end
   end

   mtcd_task_mem #(
      .DEPTH (NUM_TASKS),
      .AW    (TASK_AW),
      .WIDTH (32)
   ) u_task_mem (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .wrEn   (memWrEn),
      .wrAddr (cmdTaskNum),
      .wrData (staging_reg),
      .rdEn   (memRdEn),
      .rdAddr (memRdAddr),
      .rdData (memRdData)
   );

   // command status pulses; load completes one cycle after its read
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         loadPend_reg <= 1'b0;
         cmdDone      <= 1'b0;
         cmdError     <= 1'b0;
      end else begin
         loadPend_reg <= loadTaskCommand && modeOk &&
                         state_reg != ST_FETCH;
         cmdDone      <= memWrEn || loadPend_reg;
         cmdError     <= (commitTaskCommand &&
                          (!modeOk || !stagingValid)) ||
                         (loadTaskCommand &&
                          (!modeOk || state_reg == ST_FETCH));
      end
   end

   // a trigger is refused outside position mode, during fetch or decode, or by a locked task
   assign trigTake = triggerReq && modeOk &&
                     state_reg != ST_FETCH && state_reg != ST_DECODE &&
                     !(state_reg == ST_RUN && activeF_reg.lockTrigger);

   // chained start when the running task stops
   assign chainGo = state_reg == ST_RUN && motionDone &&
                    activeF_reg.chain;

   // a no-standstill task may only interrupt a moving one
   assign startOk = !fetchedF.noStandstill || wasRunning_reg;

   // target computation from the task type
   always_comb begin
      case (fetchedF.taskType)
         TYPE_REL_CMD:  targetCalc = commandedPosition + taskPositionValue;
         TYPE_REL_PREV: targetCalc = prevTarget_reg + taskPositionValue;
         TYPE_REL_FB:   targetCalc = feedbackPosition + taskPositionValue;
         default:       targetCalc = taskPositionValue;
      endcase
   end

   // millisecond base and following-delay countdown
   assign delayDone = delayCnt_reg == 16'h0000;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         msCnt_reg    <= '0;
         delayCnt_reg <= '0;
      end else if (state_reg != ST_DELAY) begin
         msCnt_reg    <= '0;
         delayCnt_reg <= followingDelayTime;
      end else if (msCnt_reg == 17'(MS_CYC - 1)) begin
         msCnt_reg <= '0;
         if (!delayDone) begin
            delayCnt_reg <= delayCnt_reg - 16'h0001;
         end
      end else begin
         msCnt_reg <= msCnt_reg + 17'h00001;
      end
   end

   // sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:   if (trigTake) state_next = ST_FETCH;
         ST_FETCH:  state_next = ST_DECODE;
         ST_DECODE: state_next = startOk ? ST_RUN : ST_IDLE;
         ST_RUN: begin
            if (trigTake) begin
               state_next = ST_FETCH;
            end else if (chainGo) begin
               if (activeF_reg.nextStart == NEXT_AFTER_DELAY) begin
                  state_next = ST_DELAY;
               end else begin
                  state_next = ST_FETCH;
               end
            end else if (motionDone) begin
               state_next = ST_IDLE;
            end
         end
         ST_DELAY: begin
            if (trigTake || delayDone) begin
               state_next = ST_FETCH;
            end
         end
         default:   state_next = ST_IDLE;
      endcase
      // leaving position mode drops any task in hand
      if (!modeOk) begin
         state_next = ST_IDLE;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // which task to fetch and whether motion is still under way
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fetchTask_reg    <= '0;
         fetchChained_reg <= 1'b0;
         wasRunning_reg   <= 1'b0;
      end else if (trigTake) begin
         fetchTask_reg    <= triggerTaskNum;
         fetchChained_reg <= 1'b0;
         wasRunning_reg   <= state_reg == ST_RUN;
      end else if (chainGo || (state_reg == ST_DELAY && delayDone)) begin
         fetchTask_reg    <= nextTaskNum;
         fetchChained_reg <= 1'b1;
         // only a fly-over keeps the axis moving into the next task
         wasRunning_reg   <= state_reg == ST_RUN &&
                             activeF_reg.nextStart == NEXT_ON_THE_FLY;
      end
   end

   // trigger answers: accepted on start, rejected on refusal
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         triggerAccepted <= 1'b0;
         triggerRejected <= 1'b0;
      end else begin
         triggerAccepted <= state_reg == ST_DECODE && startOk &&
                            !fetchChained_reg;
         triggerRejected <= (triggerReq && !trigTake) ||
                            (state_reg == ST_DECODE && !startOk &&
                             !fetchChained_reg);
      end
   end

   // latch the decoded task toward the profile generator
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         activeF_reg    <= mtcd_ctrl_t'(CTRL_WORD_RESET);
         activeTaskNum  <= '0;
         targetPosition <= '0;
         prevTarget_reg <= '0;
         profileShape   <= SHAPE_TRAPEZOID;
         tableProfile   <= 1'b0;
         tableSelect    <= '0;
         overrideActive <= 1'b0;
         taskStart      <= 1'b0;
      end else begin
         taskStart <= 1'b0;
         if (state_reg == ST_DECODE && startOk && modeOk) begin
            activeF_reg    <= fetchedF;
            activeTaskNum  <= fetchTask_reg;
            targetPosition <= targetCalc;
            prevTarget_reg <= targetCalc;
            profileShape   <= fetchedF.shape;
            tableProfile   <= fetchedF.shape != SHAPE_TRAPEZOID;
            tableSelect    <= (fetchedF.shape != SHAPE_TRAPEZOID) ?
                              profileTableNumber : 8'h00;
            overrideActive <= fetchedF.overrideEn &&
                              fetchedF.shape == SHAPE_TRAPEZOID;
            taskStart      <= 1'b1;
         end
      end
   end

   // running level and fly-over request to the generator
   assign taskRunning = state_reg == ST_RUN;
   assign flyToNext   = state_reg == ST_RUN && activeF_reg.chain &&
                        activeF_reg.nextStart == NEXT_ON_THE_FLY &&
                        (activeF_reg.shape == SHAPE_TRAPEZOID ||
                         activeF_reg.shape == SHAPE_TABLE_STD);

endmodule
`default_nettype wire

//--- tb/mtcd_properties.sv
// checker: port-level properties of the task control word decoder
`timescale 1ns/100ps
`default_nettype none
module mtcd_checker
   import mtcd_pkg::*;
(
   // clock, reset and mode
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [3:0]  opMode,
   // register port
   input wire logic        regRdEn,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regRdData,
   input wire logic        regRdValid,
   // commands and triggers
   input wire logic        commitTaskCommand,
   input wire logic        loadTaskCommand,
   input wire logic        cmdDone,
   input wire logic        cmdError,
   input wire logic        triggerReq,
   input wire logic        triggerAccepted,
   input wire logic        triggerRejected,
   // generator side
   input wire logic        motionDone,
   input wire logic        taskStart,
   input wire logic        taskRunning,
   input wire logic [1:0]  profileShape,
   input wire logic        tableProfile,
   input wire logic [7:0]  tableSelect,
   input wire logic        overrideActive,
   input wire logic        flyToNext
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // host start: accept and start together
   sequence s_hostStart;
      triggerAccepted ##0 taskStart;
   endsequence
   sequence s_offMode;
      opMode != OPMODE_POSITION;
   endsequence

   a_read_answer: assert property (regRdEn |=> regRdValid)
      else $error("read strobe without valid");
   a_unmapped_zero: assert property (
      regRdEn && regAddr != CTRL_WORD_OFFSET |=> regRdData == 32'h0)
      else $error("unmapped read not zero");
   a_cmd_offmode: assert property (
      s_offMode ##0 (commitTaskCommand || loadTaskCommand)
      |=> cmdError && !cmdDone)
      else $error("off-mode command not refused");
   a_trig_offmode: assert property (
      s_offMode ##0 triggerReq |=> triggerRejected && !triggerAccepted)
      else $error("off-mode trigger not refused");
   a_commit_answer: assert property (
      commitTaskCommand && opMode == OPMODE_POSITION
      |=> cmdDone || cmdError)
      else $error("commit without answer");
   a_accept_walk: assert property (s_hostStart |-> $past(triggerReq, 3))
      else $error("accept not 3 cycles after trigger");
   a_done_stops: assert property (
      taskRunning && motionDone |=> !taskRunning)
      else $error("task still running after done");
   a_start_spacing: assert property (taskStart |=> !taskStart [*2])
      else $error("starts too close together");
   a_override_trap: assert property (
      overrideActive |-> profileShape == SHAPE_TRAPEZOID)
      else $error("override on table profile");
   a_table_flag: assert property (
      tableProfile == (profileShape != SHAPE_TRAPEZOID))
      else $error("table flag disagrees with shape");
   a_table_select: assert property (!tableProfile |-> tableSelect == 8'h00)
      else $error("table selected for trapezoid");
   a_fly_shape: assert property (
      flyToNext |-> taskRunning && profileShape != SHAPE_TABLE_1TO1)
      else $error("fly-over on one-to-one table");
endmodule

bind mtcd_decoder mtcd_checker u_chk (
   .mclk, .rst_n, .opMode, .regRdEn, .regAddr, .regRdData, .regRdValid,
   .commitTaskCommand, .loadTaskCommand, .cmdDone, .cmdError, .triggerReq,
   .triggerAccepted, .triggerRejected, .motionDone, .taskStart,
   .taskRunning, .profileShape, .tableProfile, .tableSelect,
   .overrideActive, .flyToNext
);
`default_nettype wire

//--- tb/mtcd_motion_model.sv
// profile generator model: ends each started move after a set time
`timescale 1ns/100ps
`default_nettype none
module mtcd_motion_model #(
   parameter int POS_W = 32
) (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   // task start from the decoder
   input  wire logic                    taskStart,
   input  wire logic signed [POS_W-1:0] targetPosition,
   // bench controls: hold keeps the axis moving
   input  wire logic                    holdMotion,
   input  wire logic [7:0]              moveCycles,
   // answers to the decoder
   output logic                         motionDone,
   output logic signed [POS_W-1:0]      commandedPosition,
   output logic signed [POS_W-1:0]      feedbackPosition
);
   logic [7:0] cnt_reg;

   // commanded jumps to the target as the move ends
   always_ff @(posedge mclk) begin
      motionDone <= 1'b0;
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         commandedPosition <= '0;
      end else if (taskStart) begin
         cnt_reg <= moveCycles;
      end else if (cnt_reg != 8'h00 && !holdMotion) begin
         cnt_reg <= cnt_reg - 8'h01;
         if (cnt_reg == 8'h01) begin
            motionDone <= 1'b1;
            commandedPosition <= targetPosition;
         end
      end
   end

   // feedback lags by a small following error
   assign feedbackPosition = commandedPosition - 2;
endmodule
`default_nettype wire

//--- tb/mtcd_decoder_tb.sv
// testbench: register, command and trigger sequences for the decoder
`timescale 1ns/100ps
`default_nettype none
module mtcd_decoder_tb;
   import mtcd_pkg::*;
   localparam int MS = 4;
   logic               mclk = 1'b0, rst_n = 1'b0, holdMotion = 1'b0;
   logic               regWrEn = 1'b0, regRdEn = 1'b0, triggerReq = 1'b0;
   logic               commitTaskCommand = 1'b0, loadTaskCommand = 1'b0;
   logic [3:0]         opMode = OPMODE_POSITION;
   logic [11:0]        regAddr = 12'h000;
   logic [31:0]        regWrData = 32'h0, regRdData;
   logic [6:0]         cmdTaskNum = 7'h0, triggerTaskNum = 7'h0;
   logic [6:0]         nextTaskNum = 7'h0, activeTaskNum;
   logic signed [31:0] taskPositionValue = 32'h0, targetPosition;
   logic signed [31:0] commandedPosition, feedbackPosition;
   logic [7:0]         profileTableNumber = 8'h5a, tableSelect;
   logic [7:0]         moveCycles = 8'h0a;
   logic [15:0]        followingDelayTime = 16'h0002;
   logic [1:0]         profileShape;
   logic               regRdValid, cmdDone, cmdError, triggerAccepted;
   logic               triggerRejected, motionDone, taskStart, taskRunning;
   logic               tableProfile, overrideActive, flyToNext;
   mtcd_ctrl_t         ctl;
   logic [31:0]        pos, expT, prev, cmdPos;
   int                 failures = 0, tests_run = 0, cyc = 0, k, gap;
   logic [31:0]        badWord [7] = '{32'h2, 32'h8, 32'h5, 32'h40,
                                       32'h800, 32'h8000, 32'h710};
   logic [31:0]        goodWord [4] = '{32'h1000, 32'h1, 32'h403, 32'h1c07};
   logic [31:0]        chainWord [3] = '{32'h10, 32'h30, 32'h310};

   mtcd_decoder #(.MS_CYC(MS)) dut (
      .mclk, .rst_n, .opMode, .regWrEn, .regRdEn, .regAddr, .regWrData,
      .regRdData, .regRdValid, .commitTaskCommand, .loadTaskCommand,
      .cmdTaskNum, .cmdDone, .cmdError, .triggerReq, .triggerTaskNum,
      .triggerAccepted, .triggerRejected, .taskPositionValue,
      .profileTableNumber, .followingDelayTime, .nextTaskNum,
      .commandedPosition, .feedbackPosition, .motionDone, .taskStart,
      .taskRunning, .targetPosition, .profileShape, .tableProfile,
      .tableSelect, .overrideActive, .flyToNext, .activeTaskNum);

   mtcd_motion_model u_gen (
      .mclk, .rst_n, .taskStart, .targetPosition, .holdMotion, .moveCycles,
      .motionDone, .commandedPosition, .feedbackPosition);

   // 125 MHz clock
   always #4 mclk = ~mclk;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // hang guard: whole run needs a few hundred cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge mclk) regWrEn <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(logic [11:0] a, logic [31:0] e);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge mclk) regRdEn <= 1'b0;
      @(negedge mclk);
      chk("regRdData", e, regRdData);
      @(posedge mclk);
   endtask

   // either answer flag ends the wait
   task automatic cmd(logic ld, logic [6:0] n, logic expErr);
      commitTaskCommand <= !ld;
      loadTaskCommand <= ld;
      cmdTaskNum <= n;
      @(posedge mclk);
      commitTaskCommand <= 1'b0;
      loadTaskCommand <= 1'b0;
      @(negedge mclk);
      for (k = 1; k < 4 && cmdDone !== 1'b1 && cmdError !== 1'b1; k++)
         @(negedge mclk);
      chk("cmdError", expErr, cmdError);
      chk("cmdDone", !expErr, cmdDone);
      @(posedge mclk);
   endtask

   task automatic trig(logic [6:0] n, logic expAcc);
      triggerTaskNum <= n;
      triggerReq <= 1'b1;
      @(posedge mclk) triggerReq <= 1'b0;
      @(negedge mclk);
      for (k = 1; k < 6 && triggerAccepted !== 1'b1 &&
           triggerRejected !== 1'b1; k++)
         @(negedge mclk);
      chk("triggerAccepted", expAcc, triggerAccepted);
      chk("triggerRejected", !expAcc, triggerRejected);
      @(posedge mclk);
   endtask

   task automatic waitIdle();
      for (k = 0; k < 200 && taskRunning !== 1'b0; k++)
         @(negedge mclk);
      repeat (2) @(posedge mclk);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(CTRL_WORD_OFFSET, CTRL_WORD_RESET);
      rd(12'h218, 32'h0);
      wr(CTRL_WORD_OFFSET, 32'habcd_0007);
      opMode <= 4'h0;
      wr(CTRL_WORD_OFFSET, 32'h1);
      cmd(1'b0, 7'd5, 1'b1);
      trig(7'd5, 1'b0);
      opMode <= OPMODE_POSITION;
      rd(CTRL_WORD_OFFSET, 32'habcd_0007);
      cmd(1'b0, 7'd5, 1'b0);
      wr(CTRL_WORD_OFFSET, 32'h0);
      cmd(1'b1, 7'd5, 1'b0);
      rd(CTRL_WORD_OFFSET, 32'habcd_0007);
      foreach (badWord[i]) begin
         wr(CTRL_WORD_OFFSET, badWord[i]);
         cmd(1'b0, 7'd6, 1'b1);
      end
      $display("test staging and commit done");
      // task 2 stays held and is preempted by task 3
      prev = 32'h0;
      cmdPos = 32'h0;
      for (int i = 0; i < 4; i++) begin
         ctl = goodWord[i];
         pos = 32'h100 << i;
         wr(CTRL_WORD_OFFSET, goodWord[i]);
         cmd(1'b0, 7'(i + 1), 1'b0);
         taskPositionValue <= pos;
         holdMotion <= (i == 1);
         trig(7'(i + 1), 1'b1);
         case (ctl.taskType)
            TYPE_ABSOLUTE: expT = pos;
            TYPE_REL_CMD:  expT = cmdPos + pos;
            TYPE_REL_PREV: expT = prev + pos;
            default:       expT = cmdPos - 2 + pos;
         endcase
         chk("targetPosition", expT, targetPosition);
         chk("profileShape", ctl.shape, profileShape);
         chk("tableSelect", ctl.shape != 0 ? 8'h5a : 8'h0, tableSelect);
         chk("overrideActive", ctl.overrideEn && ctl.shape == 0,
             overrideActive);
         prev = expT;
         if (i != 1) begin
            waitIdle();
            cmdPos = expT;
         end
      end
      $display("test target and shape done");
      nextTaskNum <= 7'd1;
      moveCycles <= 8'h03;
      foreach (chainWord[i]) begin
         wr(CTRL_WORD_OFFSET, chainWord[i]);
         cmd(1'b0, 7'd10, 1'b0);
         trig(7'd10, 1'b1);
         chk("flyToNext", i == 2, flyToNext);
         for (k = 0; k < 100 && motionDone !== 1'b1; k++)
            @(negedge mclk);
         for (gap = 0; gap < 100 && taskStart !== 1'b1; gap++)
            @(negedge mclk);
         chk("chainGap", i == 1 ? gap >= 2 * MS : gap <= 4, 1'b1);
         chk("activeTaskNum", 7'd1, activeTaskNum);
         @(posedge mclk);
         waitIdle();
         chk("taskRunning", 1'b0, taskRunning);
      end
      $display("test chaining done");
      wr(CTRL_WORD_OFFSET, 32'h2000);
      cmd(1'b0, 7'd12, 1'b0);
      wr(CTRL_WORD_OFFSET, 32'h4000);
      cmd(1'b0, 7'd13, 1'b0);
      trig(7'd13, 1'b0);
      holdMotion <= 1'b1;
      trig(7'd12, 1'b1);
      trig(7'd1, 1'b0);
      holdMotion <= 1'b0;
      waitIdle();
      holdMotion <= 1'b1;
      trig(7'd1, 1'b1);
      trig(7'd13, 1'b1);
      trig(7'd1, 1'b1);
      holdMotion <= 1'b0;
      waitIdle();
      $display("test lock and standstill done");
      print_verdict();
   end
endmodule
`default_nettype wire
